// ---- rtl/motion_cmd_pkg.sv ----
// constants and types shared by the motion command decoder
// Functional notes
// - code 1: velocity mode, load velocity, count up
// - code 2: velocity mode, load velocity, count down
// - rotate velocity counts microsteps per second
// - axis 0..2; rotate and stop type 0
// - code 3: velocity mode, target speed zero
// - code 4: ramped move toward target position
// - move reply immediate; later commands accepted
// - move type: 0 absolute, 1 offset, 2 stored
// - positions are signed 32-bit values
// - offset move adds actual position; host bounds
// - wrapped distance; sign picks shorter direction
// - move writes target position parameter
// - stop or rotate abandons running move
// - stored move: index 0..20, fetch stored point
// - frame: addr, instr, type, axis, value MSB-first, sum
// - negative operands are two's complement
package motion_cmd_pkg;
    localparam int FRAME_LEN = 9;
    localparam logic [3:0] IDX_ADDR = 4'h0;
    localparam logic [3:0] IDX_INSTR = 4'h1;
    localparam logic [3:0] IDX_TYPE = 4'h2;
    localparam logic [3:0] IDX_AXIS = 4'h3;
    localparam logic [3:0] IDX_VAL_FIRST = 4'h4;
    localparam logic [3:0] IDX_VAL_LAST = 4'h7;
    localparam logic [3:0] IDX_SUM = 4'h8;
    localparam int NUM_AXES = 3;
    localparam logic [7:0] LAST_AXIS = 8'h02;
    localparam logic [31:0] LAST_POINT_INDEX = 32'h0000_0014;
    localparam logic [7:0] rotate_positive_cmd = 8'h01;
    localparam logic [7:0] rotate_negative_cmd = 8'h02;
    localparam logic [7:0] soft_stop_cmd = 8'h03;
    localparam logic [7:0] move_to_target_cmd = 8'h04;
    localparam logic [7:0] absolute_move_type = 8'h00;
    localparam logic [7:0] offset_move_type = 8'h01;
    localparam logic [7:0] stored_point_move_type = 8'h02;
    localparam logic [7:0] ROTATE_STOP_TYPE = 8'h00;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_SUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [3:0] REPLY_LAST = 4'h8;
    localparam logic [31:0] VELOCITY_RESET = 32'h0000_0000;
    localparam logic [31:0] POSITION_RESET = 32'h0000_0000;
    typedef enum logic [1:0] {
        OP_ROT_POS = 2'b00,
        OP_ROT_NEG = 2'b01,
        OP_STOP = 2'b10,
        OP_MOVE = 2'b11
    } axis_op_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_APPLY = 2'b10,
        ST_REPLY = 2'b11
    } dec_state_t;
endpackage : motion_cmd_pkg

// ---- rtl/frame_collector.sv ----
// gathers nine command bytes into fields and checks the byte sum
`timescale 1ns/1ps
`default_nettype none
module frame_collector
    import motion_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // byte stream
    input wire logic byte_take,
    input wire logic [7:0] byte_data,
    // assembled frame
    output logic frame_valid,
    output logic sum_ok,
    output logic [7:0] frame_addr,
    output logic [7:0] frame_instr,
    output logic [7:0] frame_type,
    output logic [7:0] frame_axis,
    output logic [31:0] frame_value
);
    logic [3:0] idx_q;
    logic [7:0] sum_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= 4'h0;
            sum_q <= 8'h00;
        end else if (ce && byte_take) begin
            // modulo-256 sum wraps in the 8-bit adder
            sum_q <= (idx_q == IDX_SUM) ? 8'h00 : 8'(sum_q + byte_data);
            idx_q <= (idx_q == IDX_SUM) ? 4'h0 : 4'(idx_q + 4'h1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_addr <= 8'h00;
            frame_instr <= 8'h00;
            frame_type <= 8'h00;
            frame_axis <= 8'h00;
            frame_value <= 32'h0000_0000;
        end else if (ce && byte_take) begin
            if (idx_q == IDX_ADDR) frame_addr <= byte_data;
            if (idx_q == IDX_INSTR) frame_instr <= byte_data;
            if (idx_q == IDX_TYPE) frame_type <= byte_data;
            if (idx_q == IDX_AXIS) frame_axis <= byte_data;
            if (idx_q >= IDX_VAL_FIRST && idx_q <= IDX_VAL_LAST) begin
                frame_value <= {frame_value[23:0], byte_data};
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid <= 1'b0;
            sum_ok <= 1'b0;
        end else if (ce) begin
            frame_valid <= byte_take && (idx_q == IDX_SUM);
            if (byte_take && idx_q == IDX_SUM) sum_ok <= (sum_q == byte_data);
        end
    end
endmodule : frame_collector
`default_nettype wire

// ---- rtl/axis_target.sv ----
// per-axis target parameters driven by decoded motion commands
`timescale 1ns/1ps
`default_nettype none
module axis_target
    import motion_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // command
    input wire logic cmd_valid,
    input wire axis_op_t cmd_op,
    input wire logic [31:0] cmd_value,
    // ramp generator feedback
    input wire logic [31:0] actual_pos,
    input wire logic target_reached,
    // targets
    output logic velocity_mode,
    output logic rotate_negative,
    output logic [31:0] target_velocity,
    output logic [31:0] target_position,
    output logic move_active,
    output logic move_negative
);
    logic [31:0] distance;

    // wraps in 32 bits on purpose: sign gives the shorter path
    assign distance = 32'(cmd_value - actual_pos);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            velocity_mode <= 1'b1;
            rotate_negative <= 1'b0;
            target_velocity <= VELOCITY_RESET;
        end else if (ce && cmd_valid) begin
            unique case (cmd_op)
                OP_ROT_POS: begin
                    velocity_mode <= 1'b1;
                    rotate_negative <= 1'b0;
                    target_velocity <= cmd_value;
                end
                OP_ROT_NEG: begin
                    velocity_mode <= 1'b1;
                    rotate_negative <= 1'b1;
                    target_velocity <= cmd_value;
                end
                OP_STOP: begin
                    velocity_mode <= 1'b1;
                    target_velocity <= VELOCITY_RESET;
                end
                OP_MOVE: velocity_mode <= 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            target_position <= POSITION_RESET;
            move_active <= 1'b0;
            move_negative <= 1'b0;
        end else if (ce) begin
            if (cmd_valid && cmd_op == OP_MOVE) begin
                target_position <= cmd_value;
                move_active <= 1'b1;
                move_negative <= distance[31];
            end else if (cmd_valid) begin
                move_active <= 1'b0;
            end else if (target_reached) begin
                move_active <= 1'b0;
            end
        end
    end
endmodule : axis_target
`default_nettype wire

// ---- rtl/motion_command_decoder.sv ----
// decodes nine-byte motion command frames and answers each frame for its own address with a reply frame
`timescale 1ns/1ps
`default_nettype none
module motion_command_decoder
    import motion_cmd_pkg::*;
#(
    parameter logic [7:0] MODULE_ADDR = 8'h01,
    parameter logic [7:0] REPLY_ADDR = 8'h02
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // command bytes from the host
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    // reply bytes to the host
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    // stored point table, read with one cycle of latency
    output logic [4:0] point_index,
    input wire logic [31:0] point_value,
    // ramp generator feedback
    input wire logic [NUM_AXES-1:0][31:0] actual_pos,
    input wire logic [NUM_AXES-1:0] target_reached,
    // axis targets
    output logic [NUM_AXES-1:0] velocity_mode,
    output logic [NUM_AXES-1:0] rotate_negative,
    output logic [NUM_AXES-1:0][31:0] target_velocity,
    output logic [NUM_AXES-1:0][31:0] target_position,
    output logic [NUM_AXES-1:0] move_active,
    output logic [NUM_AXES-1:0] move_negative
);
    dec_state_t state_q;
    dec_state_t state_d;

    logic frame_valid;
    logic sum_ok;
    logic [7:0] frame_addr;
    logic [7:0] frame_instr;
    logic [7:0] frame_type;
    logic [7:0] frame_axis;
    logic [31:0] frame_value;

    logic addr_match;
    logic [7:0] status_d;
    logic is_stored;
    logic load_reply;
    logic [7:0] reply_status;
    logic [7:0] reply_sum;
    logic [71:0] reply_q;
    logic [3:0] reply_cnt_q;

    logic [1:0] axis_sel;
    axis_op_t op_d;
    logic [31:0] apply_value;
    logic [NUM_AXES-1:0] axis_cmd_valid;

    // bytes are only taken while idle and not holding a finished frame
    assign rx_ready = ce && (state_q == ST_IDLE) && !frame_valid;

    frame_collector u_collector (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .byte_take(rx_valid && rx_ready),
        .byte_data(rx_data),
        .frame_valid(frame_valid),
        .sum_ok(sum_ok),
        .frame_addr(frame_addr),
        .frame_instr(frame_instr),
        .frame_type(frame_type),
        .frame_axis(frame_axis),
        .frame_value(frame_value)
    );

    assign addr_match = (frame_addr == MODULE_ADDR);
    assign axis_sel = frame_axis[1:0];
    assign is_stored = (frame_instr == move_to_target_cmd) && (frame_type == stored_point_move_type);

    // validation, in order of precedence
    always_comb begin
        status_d = STATUS_OK;
        if (!sum_ok) begin
            status_d = STATUS_BAD_SUM;
        end else if (frame_instr < rotate_positive_cmd || frame_instr > move_to_target_cmd) begin
            status_d = STATUS_BAD_CMD;
        end else if (frame_instr != move_to_target_cmd && frame_type != ROTATE_STOP_TYPE) begin
            status_d = STATUS_BAD_TYPE;
        end else if (frame_instr == move_to_target_cmd && frame_type > stored_point_move_type) begin
            status_d = STATUS_BAD_TYPE;
        end else if (frame_axis > LAST_AXIS) begin
            status_d = STATUS_BAD_VALUE;
        end else if (is_stored && frame_value > LAST_POINT_INDEX) begin
            status_d = STATUS_BAD_VALUE;
        end
    end

    // operation and operand handed to the selected axis
    always_comb begin
        unique case (frame_instr)
            rotate_positive_cmd: op_d = OP_ROT_POS;
            rotate_negative_cmd: op_d = OP_ROT_NEG;
            soft_stop_cmd: op_d = OP_STOP;
            default: op_d = OP_MOVE;
        endcase
    end

    always_comb begin
        apply_value = frame_value;
        if (frame_instr == move_to_target_cmd) begin
            unique case (frame_type)
                offset_move_type: begin
                    // host keeps the sum in range; no saturation here
                    apply_value = 32'(frame_value + actual_pos[axis_sel]);
                end
                stored_point_move_type: apply_value = point_value;
                default: apply_value = frame_value;
            endcase
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                // frames for another address are dropped without a reply
                if (frame_valid && addr_match) begin
                    if (status_d != STATUS_OK) begin
                        state_d = ST_REPLY;
                    end else if (is_stored) begin
                        state_d = ST_FETCH;
                    end else begin
                        state_d = ST_APPLY;
                    end
                end
            end
            ST_FETCH: state_d = ST_APPLY;
            // the move is only started, so the reply goes out at once
            ST_APPLY: state_d = ST_REPLY;
            ST_REPLY: begin
                if (tx_ready && reply_cnt_q == REPLY_LAST) state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            point_index <= 5'h00;
        end else if (ce && state_q == ST_IDLE && frame_valid) begin
            point_index <= frame_value[4:0];
        end
    end

    // one command pulse to the addressed axis
    always_comb begin
        axis_cmd_valid = '0;
        if (state_q == ST_APPLY) axis_cmd_valid[axis_sel] = 1'b1;
    end

    genvar ax;
    generate
        for (ax = 0; ax < NUM_AXES; ax++) begin : g_axis
            axis_target u_axis (
                .clk(clk),
                .rst_n(rst_n),
                .ce(ce),
                .cmd_valid(axis_cmd_valid[ax]),
                .cmd_op(op_d),
                .cmd_value(apply_value),
                .actual_pos(actual_pos[ax]),
                .target_reached(target_reached[ax]),
                .velocity_mode(velocity_mode[ax]),
                .rotate_negative(rotate_negative[ax]),
                .target_velocity(target_velocity[ax]),
                .target_position(target_position[ax]),
                .move_active(move_active[ax]),
                .move_negative(move_negative[ax])
            );
        end
    endgenerate

    // reply: addr, module addr, status, instr, value (zero), sum
    assign load_reply = (state_q == ST_APPLY) ||
                        (state_q == ST_IDLE && state_d == ST_REPLY);
    assign reply_status = (state_q == ST_APPLY) ? STATUS_OK : status_d;
    assign reply_sum = 8'(REPLY_ADDR + MODULE_ADDR + reply_status + frame_instr);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reply_q <= '0;
            reply_cnt_q <= 4'h0;
        end else if (ce) begin
            if (load_reply) begin
                reply_q <= {REPLY_ADDR, MODULE_ADDR, reply_status, frame_instr,
                            32'h0000_0000, reply_sum};
                reply_cnt_q <= 4'h0;
            end else if (state_q == ST_REPLY && tx_ready) begin
                reply_q <= {reply_q[63:0], 8'h00};
                reply_cnt_q <= 4'(reply_cnt_q + 4'h1);
            end
        end
    end

    assign tx_valid = ce && (state_q == ST_REPLY);
    assign tx_data = reply_q[71:64];
endmodule : motion_command_decoder
`default_nettype wire

// ---- verif/motion_decoder_sva.sv ----
// port assertions for the motion command decoder
`timescale 1ns/1ps
`default_nettype none
module motion_decoder_sva
    import motion_cmd_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host side
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    // axis side
    input wire logic [NUM_AXES-1:0][31:0] actual_pos,
    input wire logic [NUM_AXES-1:0] target_reached,
    input wire logic [NUM_AXES-1:0] velocity_mode,
    input wire logic [NUM_AXES-1:0] rotate_negative,
    input wire logic [NUM_AXES-1:0][31:0] target_velocity,
    input wire logic [NUM_AXES-1:0][31:0] target_position,
    input wire logic [NUM_AXES-1:0] move_active,
    input wire logic [NUM_AXES-1:0] move_negative
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence reply_wait;
        tx_valid && !tx_ready;
    endsequence
    sequence move_begin;
        !move_active[0] ##1 move_active[0];
    endsequence
    tx_hold_a: assert property (reply_wait |=> tx_valid && $stable(tx_data)) else $error("reply byte lost");
    rx_closed_a: assert property (tx_valid |-> !rx_ready) else $error("bytes taken during reply");
    rot_neg_a: assert property ($rose(rotate_negative[0]) |-> velocity_mode[0] && !move_active[0])
        else $error("down rotate outside velocity mode");
    vel_load_a: assert property ($changed(target_velocity[0]) |-> velocity_mode[0] && tx_valid)
        else $error("velocity changed without command");
    pos_load_a: assert property ($changed(target_position[0]) |-> move_active[0] && !velocity_mode[0])
        else $error("target position changed without move");
    move_reply_a: assert property (move_begin |-> tx_valid) else $error("move reply late");
    move_mode_a: assert property (move_begin |-> !velocity_mode[0]) else $error("move left velocity mode on");
    wrap_dir_a: assert property ($rose(move_active[0]) |->
        move_negative[0] == ((target_position[0] - $past(actual_pos[0])) >= 32'h8000_0000))
        else $error("move direction wrong");
    abandon_a: assert property ($fell(move_active[0]) && !$past(target_reached[0]) |-> velocity_mode[0])
        else $error("move dropped without command");
endmodule : motion_decoder_sva
`default_nettype wire

// ---- verif/motion_host_model.sv ----
// host model: sends command frames and takes reply bytes
`timescale 1ns/1ps
`default_nettype none
module motion_host_model (
    // clock
    input wire logic clk,
    // command bytes
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    // reply bytes
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic [71:0] reply;
    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
        reply = '0;
    end
    // enter just after a rising edge
    task automatic send(input logic [71:0] f);
        for (int i = 0; i < 9; i++) begin
            rx_valid <= 1'b1;
            rx_data <= f[71 - 8 * i -: 8];
            do @(negedge clk); while (!rx_ready);
            @(posedge clk);
        end
        // released line must not keep showing the last byte
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask : send
    // slow mode toggles ready so the reply has to wait
    task automatic take(input logic slow);
        int n;
        n = 0;
        while (n < 9) begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            @(negedge clk);
            if (tx_valid && tx_ready) begin
                reply = {reply[63:0], tx_data};
                n++;
            end
            @(posedge clk);
        end
        tx_ready <= 1'b0;
    endtask : take
endmodule : motion_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import motion_cmd_pkg::*;
;
    typedef struct packed {
        logic [7:0] ins;
        logic [7:0] typ;
        logic [7:0] ax;
        logic [31:0] val;
        logic bad;
        logic [7:0] st;
    } row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data;
    logic [4:0] point_index;
    logic [31:0] point_value = 32'h0;
    logic [NUM_AXES-1:0][31:0] actual_pos = {32'h0000_1000, 32'h0000_0100, 32'h0000_0010};
    logic [NUM_AXES-1:0] target_reached = 3'h0;
    logic [NUM_AXES-1:0] velocity_mode, rotate_negative, move_active, move_negative;
    logic [NUM_AXES-1:0][31:0] target_velocity, target_position;
    int mismatches = 0;
    int compares = 0;
    int cyc = 0;
    logic [31:0] tgt;
    logic [1:0] ax;
    row_t r;
    row_t rows[13] = '{
        '{8'h01, 8'h00, 8'h00, 32'h0000_C800, 1'b0, 8'h64},
        '{8'h02, 8'h00, 8'h00, 32'h0000_C800, 1'b0, 8'h64},
        '{8'h04, 8'h00, 8'h00, 32'h0001_5F90, 1'b0, 8'h64},
        '{8'h03, 8'h00, 8'h00, 32'h0000_0000, 1'b0, 8'h64},
        '{8'h04, 8'h01, 8'h02, 32'hFFFF_D8F0, 1'b0, 8'h64},
        '{8'h04, 8'h02, 8'h01, 32'h0000_0014, 1'b0, 8'h64},
        '{8'h04, 8'h00, 8'h00, 32'h8000_0010, 1'b0, 8'h64},
        '{8'h04, 8'h02, 8'h01, 32'h0000_0015, 1'b0, 8'h04},
        '{8'h03, 8'h00, 8'h03, 32'h0000_0000, 1'b0, 8'h04},
        '{8'h01, 8'h01, 8'h00, 32'h0000_0001, 1'b0, 8'h03},
        '{8'h05, 8'h00, 8'h00, 32'h0000_0000, 1'b0, 8'h02},
        '{8'h01, 8'h00, 8'h00, 32'h0000_C800, 1'b1, 8'h01},
        '{8'h01, 8'h00, 8'h00, 32'h0000_0064, 1'b0, 8'h64}
    };
    always #25 clk = ~clk;
    // point table answers one cycle after the index
    always @(posedge clk) point_value <= {8'hA5, 19'h0, point_index};
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            end_sim();
        end
    end
    motion_command_decoder #(.MODULE_ADDR(8'h01), .REPLY_ADDR(8'h02)) u_motion_command_decoder (
        .clk(clk), .rst_n(rst_n), .ce(ce), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .point_index(point_index),
        .point_value(point_value), .actual_pos(actual_pos), .target_reached(target_reached),
        .velocity_mode(velocity_mode), .rotate_negative(rotate_negative), .target_velocity(target_velocity),
        .target_position(target_position), .move_active(move_active), .move_negative(move_negative));
    motion_host_model u_motion_host_model (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
    function automatic logic [71:0] frame(input logic [7:0] a, b, c, d, input logic [31:0] v);
        logic [7:0] s;
        s = a + b + c + d + v[31:24] + v[23:16] + v[15:8] + v[7:0];
        return {a, b, c, d, v, s};
    endfunction : frame
    task automatic chk(input string what, input logic [71:0] exp, input logic [71:0] got);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_sim
    initial begin
        repeat (2) @(posedge clk);
        chk("reset", 72'({3'b111, 3'b000, 1'b0}), 72'({velocity_mode, move_active, tx_valid}));
        $display("test reset done");
        repeat (14) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            r = rows[i];
            ax = r.ax[1:0];
            u_motion_host_model.send(frame(8'h01, r.ins, r.typ, r.ax, r.val) ^ {71'h0, r.bad});
            u_motion_host_model.take(i[0]);
            chk("reply", frame(8'h02, 8'h01, r.st, r.ins, 32'h0), u_motion_host_model.reply);
            if (r.st == STATUS_OK) begin
                case (r.ins)
                    8'h01, 8'h02: begin
                        chk("velocity", 72'(r.val), 72'(target_velocity[ax]));
                        chk("rotate flags", 72'({r.ins == 8'h02, 2'b10}),
                            72'({rotate_negative[ax], velocity_mode[ax], move_active[ax]}));
                    end
                    8'h03: chk("stop", 72'({32'h0, 2'b10}),
                        72'({target_velocity[ax], velocity_mode[ax], move_active[ax]}));
                    default: begin
                        tgt = r.typ == 8'h00 ? r.val : r.typ == 8'h01 ? r.val + actual_pos[ax] :
                            {8'hA5, 19'h0, r.val[4:0]};
                        chk("target", 72'(tgt), 72'(target_position[ax]));
                        chk("move flags", 72'({2'b01, ((tgt - actual_pos[ax]) >= 32'h8000_0000)}),
                            72'({velocity_mode[ax], move_active[ax], move_negative[ax]}));
                    end
                endcase
            end
            $display("test %0d done", i);
        end
        // stop for another address must not touch axis 1
        u_motion_host_model.send(frame(8'h05, 8'h03, 8'h00, 8'h01, 32'h0));
        repeat (12) @(posedge clk);
        chk("foreign", 72'(4'b0101), 72'({tx_valid, rx_ready, velocity_mode[1], move_active[1]}));
        $display("test foreign done");
        target_reached <= 3'b010;
        @(posedge clk);
        target_reached <= 3'b000;
        @(negedge clk);
        chk("arrival", 72'(2'b00), 72'({velocity_mode[1], move_active[1]}));
        $display("test arrival done");
        // enable low: an arrival pulse on axis 2 is lost, host side closed
        @(posedge clk);
        ce <= 1'b0;
        target_reached <= 3'b100;
        @(negedge clk);
        chk("freeze", 72'(3'b001), 72'({rx_ready, tx_valid, move_active[2]}));
        @(posedge clk);
        ce <= 1'b1;
        target_reached <= 3'b000;
        @(negedge clk);
        chk("thaw", 72'(3'b101), 72'({rx_ready, tx_valid, move_active[2]}));
        $display("test freeze done");
        // second reset in mid-run, then a command straight after release
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk("reset again", 72'({3'b111, 3'b000}), 72'({velocity_mode, move_active}));
        @(posedge clk);
        u_motion_host_model.send(frame(8'h01, 8'h02, 8'h00, 8'h01, 32'h0000_0100));
        u_motion_host_model.take(1'b0);
        chk("reply after reset", frame(8'h02, 8'h01, 8'h64, 8'h02, 32'h0), u_motion_host_model.reply);
        chk("down after reset", 72'({32'h0000_0100, 2'b11}),
            72'({target_velocity[1], rotate_negative[1], velocity_mode[1]}));
        $display("test reset again done");
        end_sim();
    end
endmodule : tb_top
bind motion_command_decoder motion_decoder_sva u_motion_decoder_sva (.clk(clk), .rst_n(rst_n),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .actual_pos(actual_pos), .target_reached(target_reached), .velocity_mode(velocity_mode),
    .rotate_negative(rotate_negative), .target_velocity(target_velocity),
    .target_position(target_position), .move_active(move_active), .move_negative(move_negative));
`default_nettype wire
